// ===== verilog/madp_pin_control.sv
// module: muxed address/data pin control for the parallel port
`timescale 1ns/1ps

// Overview of operation
// R1: port-disable bit frees pins for flags
// R2: four select bits enable flag groups
// R3: pins 0-7 flags 8-15, crossed
// R4: 8-bit or 16-bit mode picks lanes
// R5: 8-bit latch phase: A15-8 low, A23-16 high
// R6: 8-bit data phase: D7-0 low, A7-0 high
// R7: 16-bit latch phase: A7-0 low, A15-8 high
// R8: 16-bit data phase: full data word
// R9: strobes float only during reset
// R10: straps 10 select parallel EPROM boot
// R11: external latch holds address on strobe fall
// R12: disable and select bits reset zero
module madp_pin_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [madp_pkg::SCR_WIDTH-1:0] system_control_register,
  input wire logic port_width_mode,
  input wire madp_pkg::madp_access_t access,
  input wire logic [madp_pkg::PIN_COUNT-1:0] general_flag_lines_out,
  input wire logic [madp_pkg::PIN_COUNT-1:0] general_flag_lines_oe_n,
  output logic [madp_pkg::PIN_COUNT-1:0] general_flag_lines_in,
  input wire logic [madp_pkg::PIN_COUNT-1:0] muxed_addr_data_pins_in,
  output madp_pkg::madp_pins_t muxed_addr_data_pins,
  output logic [madp_pkg::PIN_COUNT-1:0] read_data,
  output logic read_strobe_n_out,
  output logic read_strobe_oe_n,
  output logic write_strobe_n_out,
  output logic write_strobe_oe_n,
  output logic addr_latch_out,
  output logic addr_latch_oe_n,
  output logic port_disabled,
  output logic [madp_pkg::SCR_FLAG_SEL_WIDTH-1:0] flag_group_enable,
  input wire logic [1:0] boot_select_straps,
  output logic parallel_boot
);
  import madp_pkg::*;

  // ==========================================================
  // declarations
  // ==========================================================
  // two-stage synchronisers for pin inputs
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  // reset seen, held until the straps are caught after release
  logic rst_seen;
  // lane selection, combinational
  logic [PIN_COUNT-1:0] next_pin_out;
  logic [PIN_COUNT-1:0] next_pin_oe_n;
  logic [PIN_COUNT-1:0] port_lane;
  logic [PIN_COUNT-1:0] port_oe_n;
  // flag lines mapped onto pin order
  logic [PIN_COUNT-1:0] flag_on_pin;
  logic [PIN_COUNT-1:0] flag_oe_on_pin;
  logic [PIN_COUNT-1:0] flag_pin_sel;

  // ==========================================================
  // control register capture
  // ==========================================================
  // register the mode bits so pins change on a clean edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // R12: port mode after reset
      port_disabled <= 1'b0;
      flag_group_enable <= '0;
    end else begin
      // R1: disable bit takes the pins
      port_disabled <= system_control_register[SCR_PORT_DISABLE_BIT];
      // R2: group selects
      flag_group_enable <= system_control_register[SCR_FLAG_SEL_LSB +: SCR_FLAG_SEL_WIDTH];
    end
  end

  // ==========================================================
  // input synchronisers
  // ==========================================================
  // pins and straps come from outside the clock domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      pin_meta <= muxed_addr_data_pins_in;
      pin_sync <= pin_meta;
      strap_meta <= boot_select_straps;
      strap_sync <= strap_meta;
    end
  end

  // ==========================================================
  // boot strap capture
  // ==========================================================
  // straps sampled once, a few cycles after reset release;
  // the synchroniser is cleared under reset and refills after release
  logic [1:0] strap_wait;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_seen <= 1'b1;
      strap_wait <= 2'h0;
      parallel_boot <= 1'b0;
    end else if (rst_seen) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        rst_seen <= 1'b0;
        // R10: code 10 boots over the port
        parallel_boot <= (strap_sync == BOOT_PARALLEL_EPROM);
      end
    end
  end

  // ==========================================================
  // address / data lane selection
  // ==========================================================
  always_comb begin
    port_lane = '0;
    port_oe_n = '0;
    // R4: mode picks lane contents
    unique case (madp_width_mode_t'(port_width_mode))
      MADP_MODE_8BIT: begin
        if (access.addr_latch) begin
          // R5: upper address in latch phase
          port_lane = {access.addr[23:16], access.addr[15:8]};
        end else begin
          // R6: data low byte, low address high byte
          port_lane = {access.addr[7:0], access.wdata[7:0]};
          // low lane released on reads
          port_oe_n[LANE_WIDTH-1:0] = {LANE_WIDTH{!access.drive_data}};
        end
      end
      MADP_MODE_16BIT: begin
        if (access.addr_latch) begin
          // R7: sixteen address bits
          port_lane = access.addr[15:0];
        end else begin
          // R8: whole data word
          port_lane = access.wdata;
          port_oe_n = {PIN_COUNT{!access.drive_data}};
        end
      end
    endcase
  end

  // ==========================================================
  // flag mapping, one entry per pin
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      // R3: crossed byte order between pins and flags
      assign flag_on_pin[g] = general_flag_lines_out[(g + LANE_WIDTH) % PIN_COUNT];
      assign flag_oe_on_pin[g] = general_flag_lines_oe_n[(g + LANE_WIDTH) % PIN_COUNT];
      assign general_flag_lines_in[(g + LANE_WIDTH) % PIN_COUNT] = pin_sync[g];
      // R2: each select bit owns a group of four pins
      assign flag_pin_sel[g] = port_disabled && flag_group_enable[g / PINS_PER_GROUP];
    end
  endgenerate

  // pins not handed to flags stay released while port is off
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (flag_pin_sel[i]) begin
        next_pin_out[i] = flag_on_pin[i];
        next_pin_oe_n[i] = flag_oe_on_pin[i];
      end else if (port_disabled) begin
        next_pin_out[i] = 1'b0;
        next_pin_oe_n[i] = 1'b1;
      end else begin
        next_pin_out[i] = port_lane[i];
        next_pin_oe_n[i] = port_oe_n[i];
      end
    end
  end

  // ==========================================================
  // pin output registers
  // ==========================================================
  // registered so no combinational glitch reaches the board
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      muxed_addr_data_pins.out <= '0;
      muxed_addr_data_pins.oe_n <= '1;
      read_data <= '0;
    end else begin
      muxed_addr_data_pins.out <= next_pin_out;
      muxed_addr_data_pins.oe_n <= next_pin_oe_n;
      read_data <= pin_sync;
    end
  end

  // ==========================================================
  // strobe outputs
  // ==========================================================
  // strobes track the access one cycle late, aligned with pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // R9: floated only under reset
      read_strobe_oe_n <= 1'b1;
      write_strobe_oe_n <= 1'b1;
      addr_latch_oe_n <= 1'b1;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      addr_latch_out <= 1'b0;
    end else begin
      // R9: always driven otherwise
      read_strobe_oe_n <= 1'b0;
      write_strobe_oe_n <= 1'b0;
      addr_latch_oe_n <= 1'b0;
      // R1: disabled port parks rd/wr high, latch strobe low
      read_strobe_n_out <= access.read_strobe_n || port_disabled;
      write_strobe_n_out <= access.write_strobe_n || port_disabled;
      addr_latch_out <= access.addr_latch && !port_disabled;
    end
  end

endmodule : madp_pin_control

// ===== verilog/madp_pkg.sv
// package: constants and carriers for the muxed address/data pin control
package madp_pkg;

  // ==========================================================
  // system control register field positions
  // ==========================================================
  localparam int SCR_WIDTH = 32;
  localparam int SCR_PORT_DISABLE_BIT = 20;
  localparam int SCR_FLAG_SEL_LSB = 22;
  localparam int SCR_FLAG_SEL_WIDTH = 4;
  localparam logic [SCR_WIDTH-1:0] SCR_RESET = 32'h0000_0000;

  // ==========================================================
  // pin geometry
  // ==========================================================
  localparam int PIN_COUNT = 16;
  localparam int LANE_WIDTH = 8;
  localparam int PINS_PER_GROUP = PIN_COUNT / SCR_FLAG_SEL_WIDTH;

  // ==========================================================
  // boot strap encodings
  // ==========================================================
  localparam logic [1:0] BOOT_SPI_SLAVE = 2'h0;
  localparam logic [1:0] BOOT_SPI_MASTER = 2'h1;
  localparam logic [1:0] BOOT_PARALLEL_EPROM = 2'h2;

  // port data width mode
  typedef enum logic {
    MADP_MODE_8BIT = 1'b0,
    MADP_MODE_16BIT = 1'b1
  } madp_width_mode_t;

  // one access request from the port engine
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic drive_data;
    logic addr_latch;
    logic read_strobe_n;
    logic write_strobe_n;
  } madp_access_t;

  // three-state pin bundle, output enable active low
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe_n;
  } madp_pins_t;

endpackage : madp_pkg

// ===== test/madp_monitor.sv
// checker: port-level assertions for the muxed address/data pin control
`timescale 1ns/1ps
module madp_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [madp_pkg::SCR_WIDTH-1:0] system_control_register,
  input wire logic port_width_mode,
  input wire madp_pkg::madp_access_t access,
  input wire logic [madp_pkg::PIN_COUNT-1:0] general_flag_lines_out,
  input wire madp_pkg::madp_pins_t muxed_addr_data_pins,
  input wire logic read_strobe_oe_n,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic write_strobe_oe_n,
  input wire logic addr_latch_out,
  input wire logic addr_latch_oe_n,
  input wire logic port_disabled,
  input wire logic [madp_pkg::SCR_FLAG_SEL_WIDTH-1:0] flag_group_enable
);
  import madp_pkg::*;
  // ==========================================================
  // helper copies of last cycle's inputs
  // ==========================================================
  madp_access_t acc_q; // access one edge back
  logic [15:0] flag_q; // flag drive one edge back
  // one edge of delay matches the pin register
  always_ff @(posedge clk) begin
    acc_q <= access;
    flag_q <= general_flag_lines_out;
  end
  wire live = !port_disabled; // port serves accesses
  wire [15:0] pin = muxed_addr_data_pins.out; // pin levels driven
  wire drv = muxed_addr_data_pins.oe_n == 16'h0000; // all pins driven
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // assertions
  // ==========================================================
  strobe_drive_a: assert property (1 |=> !read_strobe_oe_n && !write_strobe_oe_n && !addr_latch_oe_n)
    else $error("strobe not driven outside reset");
  strobe_park_a: assert property (port_disabled |=> read_strobe_n_out && write_strobe_n_out && !addr_latch_out)
    else $error("strobes not parked with port off");
  port_off_a: assert property (1 |=> port_disabled == $past(system_control_register[SCR_PORT_DISABLE_BIT]))
    else $error("port disable not followed");
  flag_sel_a: assert property (1 |=> flag_group_enable ==
    $past(system_control_register[SCR_FLAG_SEL_LSB +: SCR_FLAG_SEL_WIDTH]))
    else $error("flag group select not followed");
  reset_clear_a: assert property ($fell(sys_rst) |-> !port_disabled && flag_group_enable == 4'h0)
    else $error("control bits not cleared by reset");
  narrow_addr_a: assert property (live && !port_width_mode && access.addr_latch
    |=> drv && pin == acc_q.addr[23:8])
    else $error("narrow latch lanes wrong");
  narrow_data_a: assert property (live && !port_width_mode && !access.addr_latch && access.drive_data
    |=> drv && pin == {acc_q.addr[7:0], acc_q.wdata[7:0]})
    else $error("narrow data lanes wrong");
  wide_addr_a: assert property (live && port_width_mode && access.addr_latch |=> drv && pin == acc_q.addr[15:0])
    else $error("wide latch lanes wrong");
  wide_data_a: assert property (live && port_width_mode && !access.addr_latch && access.drive_data
    |=> drv && pin == acc_q.wdata)
    else $error("wide data lanes wrong");
  flag_cross_a: assert property (port_disabled && flag_group_enable == 4'hF
    |=> pin == {flag_q[7:0], flag_q[15:8]})
    else $error("flag crossing wrong");
endmodule : madp_monitor

// ===== test/madp_mem_model.sv
// partner: external address latch, small asynchronous memory, pull-ups
`timescale 1ns/1ps
module madp_mem_model (
  input wire logic clk,
  input wire madp_pkg::madp_pins_t muxed_addr_data_pins,
  input wire logic addr_latch_out,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out,
  output logic [15:0] pad
);
  import madp_pkg::*;
  logic [15:0] mem [16]; // tiny word store
  logic [15:0] held; // latched address
  // latch follows pins while strobe high, holds after it falls
  always @(posedge clk) begin
    if (addr_latch_out) held <= pad;
    if (!write_strobe_n_out) mem[held[3:0]] <= pad;
  end
  // released lines float to the pull-up level unless memory answers a read
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!muxed_addr_data_pins.oe_n[i]) pad[i] = muxed_addr_data_pins.out[i];
      else pad[i] = !read_strobe_n_out ? mem[held[3:0]][i] : 1'b1;
    end
  end
endmodule : madp_mem_model

// ===== test/test_madp_pin_control.sv
// testbench: directed access sequences for the muxed pin control
`timescale 1ns/1ps
module test_madp_pin_control;
  import madp_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic [31:0] system_control_register = '0;
  logic port_width_mode = 1;
  madp_access_t access;
  logic [15:0] general_flag_lines_out = 16'h00FF;
  logic [15:0] general_flag_lines_oe_n = 16'h0000;
  logic [15:0] general_flag_lines_in, muxed_addr_data_pins_in, read_data;
  madp_pins_t muxed_addr_data_pins;
  logic read_strobe_n_out, read_strobe_oe_n, write_strobe_n_out, write_strobe_oe_n;
  logic addr_latch_out, addr_latch_oe_n, port_disabled, parallel_boot;
  logic [3:0] flag_group_enable;
  logic [1:0] boot_select_straps = 2'h2;
  int n_errors = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  madp_pin_control dut (.clk, .sys_rst, .system_control_register, .port_width_mode, .access,
    .general_flag_lines_out, .general_flag_lines_oe_n, .general_flag_lines_in, .muxed_addr_data_pins_in,
    .muxed_addr_data_pins, .read_data, .read_strobe_n_out, .read_strobe_oe_n, .write_strobe_n_out,
    .write_strobe_oe_n, .addr_latch_out, .addr_latch_oe_n, .port_disabled, .flag_group_enable,
    .boot_select_straps, .parallel_boot);
  madp_mem_model far (.clk, .muxed_addr_data_pins, .addr_latch_out, .read_strobe_n_out,
    .write_strobe_n_out, .pad(muxed_addr_data_pins_in));
  // ==========================================================
  // tasks
  // ==========================================================
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one port cycle, driven at the falling edge
  task automatic cyc(input logic ale, input logic [23:0] a, input logic [15:0] d, input logic drv,
    input logic rd_n, input logic wr_n);
    access = '{a, d, drv, ale, rd_n, wr_n};
    @(negedge clk);
  endtask : cyc
  // verdict
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    access = '{24'h0, 16'h0, 1'b0, 1'b0, 1'b1, 1'b1};
    repeat (6) @(negedge clk);
    chk(read_strobe_oe_n, 1);
    sys_rst = 0;
    chk(port_disabled, 0);
    cyc(1, 24'h5, 0, 0, 1, 1);
    chk(muxed_addr_data_pins.out, 16'h0005);
    chk(addr_latch_out, 1);
    cyc(0, 24'h5, 16'hA5C3, 1, 1, 0);
    chk(muxed_addr_data_pins.out, 16'hA5C3);
    chk(write_strobe_n_out, 0);
    cyc(1, 24'h5, 0, 0, 1, 1);
    repeat (5) cyc(0, 24'h5, 0, 0, 0, 1);
    chk(read_data, 16'hA5C3);
    chk(parallel_boot, 1);
    port_width_mode = 0;
    repeat (2) cyc(0, 0, 0, 0, 1, 1);
    cyc(1, 24'h123456, 0, 0, 1, 1);
    chk(muxed_addr_data_pins.out, 16'h1234);
    cyc(0, 24'h123456, 16'h009A, 1, 1, 0);
    chk(muxed_addr_data_pins.out, 16'h569A);
    cyc(0, 24'h123456, 0, 0, 0, 1);
    chk(muxed_addr_data_pins.oe_n, 16'h00FF);
    system_control_register = 32'h03D0_0000;
    general_flag_lines_oe_n = 16'h00F0;
    repeat (6) cyc(0, 0, 0, 0, 0, 1);
    chk(read_strobe_n_out, 1);
    chk(muxed_addr_data_pins.out, 16'hFF00);
    chk(muxed_addr_data_pins.oe_n, 16'hF000);
    chk(general_flag_lines_in, 16'h00FF);
    system_control_register = 32'h0050_0000;
    repeat (3) @(negedge clk);
    chk(muxed_addr_data_pins.oe_n, 16'hFFF0);
    // second reset in mid-run, with other strap code
    sys_rst = 1;
    boot_select_straps = 2'h1;
    repeat (2) @(negedge clk);
    chk(port_disabled, 0);
    chk(flag_group_enable, 4'h0);
    chk(write_strobe_oe_n, 1);
    sys_rst = 0;
    @(negedge clk);
    chk(addr_latch_oe_n, 0);
    chk(write_strobe_oe_n, 0);
    repeat (2) @(negedge clk);
    chk(parallel_boot, 0);
    end_of_test();
  end
endmodule : test_madp_pin_control

bind madp_pin_control madp_monitor mon (.clk, .sys_rst, .system_control_register, .port_width_mode, .access,
  .general_flag_lines_out, .muxed_addr_data_pins, .read_strobe_oe_n, .read_strobe_n_out, .write_strobe_n_out,
  .write_strobe_oe_n, .addr_latch_out, .addr_latch_oe_n, .port_disabled, .flag_group_enable);
